// ---- hdl/lcyc_pkg.sv ----
// package for the line-cycle energy accumulation control block
// assumes one system clock shared by the block and its power source
package lcyc_pkg;
	// datapath widths
	localparam int ACC_W = 32;
	localparam int PWR_W = 24;
	localparam int CNT_W = 16;
	localparam int NUM_PH = 3;
	localparam int NUM_CLS = 3;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// energy classes, index into the accumulator array
	localparam int CLS_ACT = 0;
	localparam int CLS_REACT = 1;
	localparam int CLS_APP = 2;

	// register indices; byte address is four times the index
	localparam logic [15:0] CFG_IDX = 16'he702;
	localparam logic [15:0] HALF_IDX = 16'he710;
	localparam logic [15:0] STAT_IDX = 16'he711;
	localparam logic [15:0] ACC_BASE_IDX = 16'he400;
	localparam int IDX_LSB = 2;

	// reset values
	localparam logic [7:0] CFG_RST = 8'h78;
	localparam logic [CNT_W-1:0] HALF_RST = 16'hffff;

	// configuration register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       power_factor_source_sel; // bit 7
		logic       clear_on_read_en;        // bit 6
		logic [2:0] zero_cross_phase_select; // bits 5:3, c b a
		logic       apparent_linecycle_en;   // bit 2
		logic       reactive_linecycle_en;   // bit 1
		logic       active_linecycle_en;     // bit 0
	} cfg_t;

	typedef logic signed [PWR_W-1:0] pwr_t;
	typedef pwr_t [NUM_CLS-1:0][NUM_PH-1:0] pwr_arr_t;
	typedef logic [ACC_W-1:0] acc_t;
	typedef acc_t [NUM_CLS-1:0][NUM_PH-1:0] acc_arr_t;
	typedef acc_t [NUM_PH-1:0] ph_acc_t;

	// apb request from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

	// power factor operands per phase
	typedef struct packed {
		ph_acc_t num; // active
		ph_acc_t den; // apparent
		logic    upd;
	} pf_t;
endpackage

// ---- hdl/lcyc_accum_ctrl.sv ----
// line-cycle energy accumulation control with apb register access
// assumes power samples and zero-crossing pulses come from logic on CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module lcyc_accum_ctrl
	import lcyc_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RST_B,
	input  wire lcyc_pkg::apb_req_t APB_REQ,
	output var  lcyc_pkg::apb_rsp_t APB_RSP,
	input  wire logic              POWER_VALID,
	input  wire lcyc_pkg::pwr_arr_t PHASE_POWER,
	input  wire logic [2:0]        ZERO_CROSS,
	output logic [2:0]             LINECYCLE_MODE,
	output logic                   PF_SOURCE_ENERGY,
	output logic                   PERIOD_END,
	output lcyc_pkg::pf_t          POWER_FACTOR
);
	import lcyc_pkg::*;

	// register map, word indices, byte address is four times the index
	// cfg at CFG_IDX: mode bits, phase select, clear on read, pf source
	// half-cycle total at HALF_IDX: sixteen bits, upper bits read zero
	// status at STAT_IDX: running crossing count, read only
	// accumulators from ACC_BASE_IDX: class times three plus phase
	// class order: active, reactive, apparent; phase order: a, b, c
	// writes to accumulators or status are refused with pslverr
	// unmapped indices are refused with pslverr and read as zero
	//
	// bus timing
	// read data is snapshotted at the setup edge and stands until
	// the next setup; the master takes it at the access edge
	// writes land at the access edge, pready is always high
	// back-to-back transfers are fine, there are no wait states
	// a clear on read acts at the access edge, after the snapshot
	//
	// crossing count
	// each cycle adds the number of selected crossing pulses
	// phases whose select bit is clear add nothing
	// two phases selected end a period in half the time
	// a total of zero never ends a period; the count keeps running and wraps
	// writing the total restarts the count from zero
	// the count is held at zero while no line-cycle bit and no
	// energy power factor bit is set, so a later enable starts clean
	//
	// accumulation
	// regular classes add every valid sample, forever
	// line-cycle classes add samples until the period ends, then
	// copy the sum, including that cycle's sample, to the result
	// and start over from zero; reads show the result
	// the period end pulse follows the completing crossing by one
	// cycle, and is the moment results and, with the energy source, power factor operands are fresh
	//
	// clear on read
	// regular classes keep energy accrued between snapshot and the
	// access edge, so a read with clear loses no sample
	// a result cleared in the cycle a new one loads keeps the new one
	// software should leave clear on read off in line-cycle mode,
	// since a read would otherwise wipe a whole period's result
	//
	// power factor operands
	// instantaneous source: each valid sample loads active and
	// apparent powers, with an update pulse one cycle later
	// energy source: each period end loads active and apparent
	// energies; the operands are only meaningful when both of these
	// classes run in line-cycle mode, which is left to software
	//
	// reset
	// synchronous, active low; all sums, results and counts zero
	// config comes back to its documented default, total to all ones
	//
	// hazards
	// power samples and crossings arrive on this clock, unsynchronised
	// a config write in the cycle of a period end uses the old config
	// accumulators wrap silently; software must read them in time
	// the signed samples are sign extended before they are summed

	typedef struct packed {
		cfg_t             cfg;
		logic [CNT_W-1:0] half;
		logic [CNT_W-1:0] zx_cnt;
		acc_arr_t         acc;   // running accumulators
		acc_arr_t         lat;   // line-cycle results
		logic [DATA_W-1:0] rdata;
		logic             period_end;
		pf_t              pf;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic              setup;
	logic              access;
	logic [15:0]       idx;
	logic              hit_acc;
	logic [1:0]        hit_cls;
	logic [1:0]        hit_ph;
	logic              mapped;
	logic [2:0]        lc_en;
	logic              lc_active;
	logic [1:0]        zx_inc;
	logic [CNT_W:0]    cnt_sum;
	logic              pend;
	acc_arr_t          inc;
	acc_arr_t          sum;
	logic [DATA_W-1:0] rd_val;

	assign setup = APB_REQ.psel & ~APB_REQ.penable;
	assign access = APB_REQ.psel & APB_REQ.penable;
	assign idx = APB_REQ.paddr[IDX_LSB +: 16];
	assign lc_en = {st_reg.cfg.apparent_linecycle_en,
		st_reg.cfg.reactive_linecycle_en,
		st_reg.cfg.active_linecycle_en};
	assign lc_active = (|lc_en) | st_reg.cfg.power_factor_source_sel;

	// address decode of the accumulator window
	always_comb begin
		hit_acc = 1'b0;
		hit_cls = 2'd0;
		hit_ph = 2'd0;
		for (int c = 0; c < NUM_CLS; c++) begin
			for (int p = 0; p < NUM_PH; p++) begin
				if (idx == ACC_BASE_IDX + 16'(c * NUM_PH + p)) begin
					hit_acc = 1'b1;
					hit_cls = 2'(c);
					hit_ph = 2'(p);
				end
			end
		end
	end

	assign mapped = hit_acc | (idx == CFG_IDX) | (idx == HALF_IDX)
		| (idx == STAT_IDX);

	// phase select
	// only crossings of selected phases are counted
	always_comb begin
		zx_inc = 2'd0;
		for (int p = 0; p < NUM_PH; p++) begin
			zx_inc = zx_inc + 2'(ZERO_CROSS[p]
				& st_reg.cfg.zero_cross_phase_select[p]);
		end
	end

	assign cnt_sum = {1'b0, st_reg.zx_cnt} + (CNT_W + 1)'(zx_inc);
	assign pend = lc_active && (st_reg.half != '0) && (zx_inc != 2'd0)
		&& (cnt_sum >= {1'b0, st_reg.half});

	// sign extended increments and running sums
	always_comb begin
		for (int c = 0; c < NUM_CLS; c++) begin
			for (int p = 0; p < NUM_PH; p++) begin
				inc[c][p] = POWER_VALID
					? ACC_W'(signed'(PHASE_POWER[c][p])) : '0;
				sum[c][p] = st_reg.acc[c][p] + inc[c][p];
			end
		end
	end

	// read value mux; line-cycle classes show the latched result
	always_comb begin
		rd_val = '0;
		if (hit_acc) begin
			rd_val = lc_en[hit_cls] ? st_reg.lat[hit_cls][hit_ph]
				: st_reg.acc[hit_cls][hit_ph];
		end else if (idx == CFG_IDX) begin
			rd_val = DATA_W'(st_reg.cfg);
		end else if (idx == HALF_IDX) begin
			rd_val = DATA_W'(st_reg.half);
		end else if (idx == STAT_IDX) begin
			rd_val = DATA_W'(st_reg.zx_cnt);
		end
	end

	// next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.period_end = pend;
		st_next.pf.upd = 1'b0;

		// snapshot read data in the setup cycle
		if (setup) begin
			st_next.rdata = rd_val;
		end

		// register writes take effect at the access edge
		if (access && APB_REQ.pwrite) begin
			if (idx == CFG_IDX) begin
				st_next.cfg = cfg_t'(APB_REQ.pwdata[7:0]);
			end
			if (idx == HALF_IDX) begin
				st_next.half = APB_REQ.pwdata[CNT_W-1:0];
			end
		end

		// zero-crossing counter
		if (!lc_active || (access && APB_REQ.pwrite && idx == HALF_IDX)) begin
			st_next.zx_cnt = '0;
		end else if (pend) begin
			st_next.zx_cnt = '0;
		end else begin
			st_next.zx_cnt = cnt_sum[CNT_W-1:0];
		end

		for (int c = 0; c < NUM_CLS; c++) begin
			for (int p = 0; p < NUM_PH; p++) begin
				// mode select
				// line-cycle classes restart the running sum each period
				if (lc_en[c] && pend) begin
					st_next.lat[c][p] = sum[c][p];
					st_next.acc[c][p] = '0;
				end else begin
					st_next.acc[c][p] = sum[c][p];
				end
			end
		end

		// clear on read
		// regular classes keep energy accrued since the snapshot, so they lose nothing
		if (access && !APB_REQ.pwrite && hit_acc
			&& st_reg.cfg.clear_on_read_en) begin
			if (lc_en[hit_cls]) begin
				if (!pend) begin
					st_next.lat[hit_cls][hit_ph] = '0;
				end
			end else begin
				st_next.acc[hit_cls][hit_ph] =
					sum[hit_cls][hit_ph] - st_reg.rdata;
			end
		end
		// with the bit clear no path above touches the contents

		// power factor operands
		if (st_reg.cfg.power_factor_source_sel) begin
			if (pend) begin
				for (int p = 0; p < NUM_PH; p++) begin
					st_next.pf.num[p] = sum[CLS_ACT][p];
					st_next.pf.den[p] = sum[CLS_APP][p];
				end
				st_next.pf.upd = 1'b1;
			end
		end else if (POWER_VALID) begin
			for (int p = 0; p < NUM_PH; p++) begin
				st_next.pf.num[p] = inc[CLS_ACT][p];
				st_next.pf.den[p] = inc[CLS_APP][p];
			end
			st_next.pf.upd = 1'b1;
		end
	end

	// state register with synchronous reset
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			st_reg <= '0;
			st_reg.cfg <= cfg_t'(CFG_RST);
			st_reg.half <= HALF_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// apb answer: zero wait states, data from the setup snapshot
	always_comb begin
		APB_RSP.pready = 1'b1;
		APB_RSP.pslverr = access & (!mapped
			| (APB_REQ.pwrite & (hit_acc | idx == STAT_IDX)));
		APB_RSP.prdata = st_reg.rdata;
	end

	assign LINECYCLE_MODE = lc_en;
	assign PF_SOURCE_ENERGY = st_reg.cfg.power_factor_source_sel;
	assign PERIOD_END = st_reg.period_end;
	assign POWER_FACTOR = st_reg.pf;
endmodule // lcyc_accum_ctrl
`default_nettype wire

// ---- tb/lcyc_accum_ctrl_props.sv ----
// port assertions for the line-cycle control block
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module lcyc_accum_props
	import lcyc_pkg::*;
(
	input wire logic               CLK_SYS,
	input wire logic               RST_B,
	input wire lcyc_pkg::apb_req_t APB_REQ,
	input wire lcyc_pkg::apb_rsp_t APB_RSP,
	input wire logic               POWER_VALID,
	input wire logic [2:0]         ZERO_CROSS,
	input wire logic [2:0]         LINECYCLE_MODE,
	input wire logic               PF_SOURCE_ENERGY,
	input wire logic               PERIOD_END,
	input wire lcyc_pkg::pf_t      POWER_FACTOR
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);
	logic        acc_ph;
	logic        cfg_wr;
	logic        mapped;
	logic [15:0] idx;
	// decode of the apb access phase
	assign idx = APB_REQ.paddr[17:2];
	assign acc_ph = APB_REQ.psel && APB_REQ.penable;
	assign cfg_wr = acc_ph && APB_REQ.pwrite && idx == CFG_IDX;
	assign mapped = idx == CFG_IDX || idx == HALF_IDX || (idx == STAT_IDX
		|| idx - ACC_BASE_IDX < 16'h0009) && !APB_REQ.pwrite;
	a_mode_follows:
		assert property (cfg_wr |=> LINECYCLE_MODE == $past(APB_REQ.pwdata[2:0]))
		else $error("mode bits differ from written config");
	a_pf_source:
		assert property (cfg_wr |=> PF_SOURCE_ENERGY == $past(APB_REQ.pwdata[7]))
		else $error("power factor source differs from config");
	a_ready_high:
		assert property (acc_ph |-> APB_RSP.pready)
		else $error("access phase without ready");
	a_refuse_err:
		assert property (acc_ph |-> APB_RSP.pslverr == !mapped)
		else $error("error response wrong for address");
	a_period_cause:
		assert property (PERIOD_END |-> $past(|ZERO_CROSS))
		else $error("period end without crossing");
	a_period_pf:
		assert property (PERIOD_END && PF_SOURCE_ENERGY |-> POWER_FACTOR.upd)
		else $error("no power factor update at period end");
	a_inst_pf:
		assert property (POWER_VALID && !PF_SOURCE_ENERGY |=> POWER_FACTOR.upd)
		else $error("no power factor update after sample");
	a_upd_cause:
		assert property (POWER_FACTOR.upd |->
			(PF_SOURCE_ENERGY ? PERIOD_END : $past(POWER_VALID)))
		else $error("power factor update without cause");
	// main scenarios seen
	cover property (PERIOD_END && PF_SOURCE_ENERGY);
	cover property (cfg_wr);
	cover property (acc_ph && APB_RSP.pslverr);
endmodule // lcyc_accum_props
bind lcyc_accum_ctrl lcyc_accum_props lcyc_accum_props_i (
	.CLK_SYS(CLK_SYS), .RST_B(RST_B), .APB_REQ(APB_REQ),
	.APB_RSP(APB_RSP), .POWER_VALID(POWER_VALID), .ZERO_CROSS(ZERO_CROSS),
	.LINECYCLE_MODE(LINECYCLE_MODE), .PF_SOURCE_ENERGY(PF_SOURCE_ENERGY),
	.PERIOD_END(PERIOD_END), .POWER_FACTOR(POWER_FACTOR));
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the line-cycle control block
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lcyc_pkg::*;
	logic        clk_sys;
	logic        rst_b;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic        pvalid;
	pwr_arr_t    power;
	logic [2:0]  zc;
	logic [2:0]  lc_mode;
	logic        pf_src;
	logic        period_end;
	pf_t         pf;
	logic [15:0] lfsr;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [32:0] p;
	int          err_count;
	int          checked;
	int          i;

	lcyc_accum_ctrl lcyc_accum_ctrl_i (.CLK_SYS(clk_sys), .RST_B(rst_b),
		.APB_REQ(req), .APB_RSP(rsp), .POWER_VALID(pvalid),
		.PHASE_POWER(power), .ZERO_CROSS(zc), .LINECYCLE_MODE(lc_mode),
		.PF_SOURCE_ENERGY(pf_src), .PERIOD_END(period_end),
		.POWER_FACTOR(pf));

	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [15:0] lfsr_next(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one apb transfer; x is the expected {pslverr, prdata}, or for writes pslverr and the write data
	task automatic apb(logic wr, logic [15:0] idx, logic [32:0] x);
		int n;
		exp_q.push_back(x);
		req <= {1'b1, 1'b0, wr, idx, 2'b00, 32'h0000_0000 | x[31:0]};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk_sys);
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
	endtask

	// one cycle of sample valid and crossing pulses
	task automatic pulse(logic pv, logic [2:0] z);
		pvalid <= pv;
		zc <= z;
		power <= {9{p[23:0]}};
		@(posedge clk_sys);
	endtask

	// completed transfers compared against the oldest note
	always @(posedge clk_sys) begin
		if (req.psel && req.penable && rsp.pready && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (req.pwrite)
				e[31:0] = rsp.prdata;
			chk("apb answer", {rsp.pslverr, rsp.prdata}, e);
		end
	end

	// main sequence
	initial begin
		err_count = 0;
		checked = 0;
		req = '0;
		pvalid = 1'b0;
		power = '0;
		zc = 3'h0;
		rst_b = 1'b0;
		lfsr = lfsr_next(16'h0063);
		p = {18'h00000, lfsr[14:0]};
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(1'b0, CFG_IDX, 33'h0_0000_0078);
		apb(1'b0, HALF_IDX, 33'h0_0000_ffff);
		apb(1'b0, 16'h0100, 33'h1_0000_0000);
		apb(1'b1, ACC_BASE_IDX, 33'h1_0000_0000);
		apb(1'b1, HALF_IDX, 33'h0_0000_0002);
		apb(1'b1, CFG_IDX, 33'h0_0000_009d);
		chk("mode", {30'h0, lc_mode}, 33'h5);
		pulse(1'b1, 3'h0);
		pulse(1'b0, 3'h4);
		zc <= 3'h0;
		apb(1'b0, STAT_IDX, 33'h0);
		pulse(1'b0, 3'h3);
		zc <= 3'h0;
		for (i = 0; i < 4 && period_end !== 1'b1; i++)
			@(negedge clk_sys);
		chk("period", {32'h0, period_end}, 33'h1);
		chk("pf num", {1'b0, pf.num[0]}, p);
		chk("pf den", {1'b0, pf.den[2]}, p);
		@(posedge clk_sys);
		apb(1'b0, ACC_BASE_IDX, p);
		apb(1'b0, ACC_BASE_IDX + 16'h0003, p);
		apb(1'b1, CFG_IDX, 33'h0_0000_0040);
		apb(1'b0, ACC_BASE_IDX + 16'h0003, p);
		apb(1'b0, ACC_BASE_IDX + 16'h0003, 33'h0);
		apb(1'b1, CFG_IDX, 33'h0);
		chk("mode", {29'h0, pf_src, lc_mode}, 33'h0);
		apb(1'b0, ACC_BASE_IDX + 16'h0004, p);
		apb(1'b0, ACC_BASE_IDX + 16'h0004, p);
		pulse(1'b1, 3'h7);
		pvalid <= 1'b0;
		zc <= 3'h0;
		@(negedge clk_sys);
		chk("pf upd", {32'h0, pf.upd}, 33'h1);
		chk("pf inst num", {1'b0, pf.num[1]}, p);
		chk("pf inst den", {1'b0, pf.den[0]}, p);
		repeat (3) @(posedge clk_sys);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
